// File: hsp_host_port.sv
`timescale 1ns/1ns
// Overview of operation
// R01: Alternate-pin bit picks alternate or primary write strobe and channel-2 select.
// R02: Channel 1 chosen when its select low and channel-2 select high; opposite for 2.
// R03: Host read returns outbound byte at address line 0, status at 1.
// R04: On host write, the address line marks the byte as command or data.
// R05: Inbound byte is host write-only, CPU read-only at FFF4 and FFFC.
// R06: Outbound byte is CPU read/write, host read-only at FFF5 and FFFD.
// R07: Status is host read-only; CPU writes bits 7-4 and 2; resets to 00.
// R08: Port control is CPU-only at FFF0, resets to F8.
// R09: System control bit 3 is read-only; other bits CPU read/write.
// R10: CPU uses fixed addresses; host uses select and address-line pins only.
// R11: Host pulls read strobe low, holding select and address line steady.
// R12: Host places byte on bus then pulls write strobe low.
// R13: Bytes travel on an 8-bit two-way data bus.
// R14: Three host interrupt outputs: one, eleven and twelve.
// R15: Write strobe rising edge loads byte and address-line level into command/data bit.
// R16: Input-full set by host write, cleared by CPU read of inbound byte.
// R17: Output-full set by CPU write, cleared by host read of outbound byte.
// R18: Port answers the host only while the port enable bit is 1.
// R19: Data bus driven only during a host read of a selected channel.
// R20: Host strobes and selects are synchronised before touching status flags.
module hsp_host_port
   import hsp_pkg::*;
#(
   parameter int FIFO_DEPTH = HSP_FIFO_DEPTH
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [15:0] CPU_ADDR,
   input wire logic CPU_WR,
   input wire logic CPU_RD,
   input wire logic [7:0] CPU_WDATA,
   output logic [7:0] CPU_RDATA,
   input wire logic HOST_READ_STROBE_N,
   input wire logic HOST_WRITE_STROBE_N,
   input wire logic ALT_HOST_WRITE_STROBE_N,
   input wire logic CHANNEL_ONE_SELECT_N,
   input wire logic CHANNEL_TWO_SELECT_N,
   input wire logic ALT_CHANNEL_TWO_SELECT_N,
   input wire logic HOST_ADDR_LINE,
   input wire logic [7:0] HOST_DATA_BUS_IN,
   output logic [7:0] HOST_DATA_BUS_OUT,
   output logic HOST_DATA_BUS_OE_N,
   output logic HOST_IRQ_ONE,
   output logic HOST_IRQ_ELEVEN,
   output logic HOST_IRQ_TWELVE,
   output logic ADDR_GATE_OUT
);
   hsp_regs_t q;
   hsp_regs_t d;
   logic alt_sel;
   logic [4:0] pins;
   logic port_enable;
   logic sel1;
   logic sel2;
   logic drain_ch;
   logic drain_go;
   logic [7:0] rd_val;

   // Queue pointers wrap freely, so only power-of-two depths are served
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
   begin : g_bad_fifo_depth
      $error("hsp_host_port: FIFO_DEPTH must be a power of two, at least 2");
   end

   hsp_fifo_if #(.W(HSP_FIFO_W)) fq ();

   // Queue decouples host write bursts from a slow CPU; a write held off by a full queue stalls new host cycles
   hsp_fifo #(.W(HSP_FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk(CLK),
      .rst(RST),
      .f(fq.fifo)
   );

   assign alt_sel = q.serial_timer_control[HSP_BIT_ALT_PIN_SELECT];
   assign pins[HSP_PIN_RD] = HOST_READ_STROBE_N;
   assign pins[HSP_PIN_WR] = alt_sel ? ALT_HOST_WRITE_STROBE_N : HOST_WRITE_STROBE_N; // R01
   assign pins[HSP_PIN_SEL1] = CHANNEL_ONE_SELECT_N;
   assign pins[HSP_PIN_SEL2] = alt_sel ? ALT_CHANNEL_TWO_SELECT_N : CHANNEL_TWO_SELECT_N; // R01
   assign pins[HSP_PIN_HA] = HOST_ADDR_LINE;

   assign port_enable = q.system_control[HSP_BIT_PORT_ENABLE];
   assign sel1 = !q.ctl_s2[HSP_PIN_SEL1] && q.ctl_s2[HSP_PIN_SEL2]; // R02
   assign sel2 = q.ctl_s2[HSP_PIN_SEL1] && !q.ctl_s2[HSP_PIN_SEL2]; // R02

   // A channel whose inbound byte is still unread holds the queue head
   assign drain_ch = fq.out_data[HSP_FIFO_CH_BIT];
   assign drain_go = fq.out_valid && !q.stat[drain_ch][HSP_BIT_INPUT_FULL];
   assign fq.out_ready = drain_go;
   assign fq.in_valid = q.push_valid;
   assign fq.in_data = q.push_data;

   always_comb
   begin
      d = q;
      rd_val = HSP_UNMAPPED_READ;
      // Two flops per pin; only the second stage is looked at
      d.ctl_s1 = pins; // R20
      d.ctl_s2 = q.ctl_s1; // R20
      d.dat_s1 = HOST_DATA_BUS_IN;
      d.dat_s2 = q.dat_s1;
      if (q.push_valid && fq.in_ready)
      begin
         d.push_valid = 1'b0;
      end

      // Host side cycle tracking
      case (q.st)
         HSP_ST_IDLE:
         begin
            d.hdb_drive = 1'b0;
            if (port_enable && !q.push_valid && (sel1 || sel2)) // R18
            begin
               if (!q.ctl_s2[HSP_PIN_RD])
               begin
                  d.st = HSP_ST_READ;
                  d.acc_ch2 = sel2;
                  d.acc_addr_line = q.ctl_s2[HSP_PIN_HA];
               end
               else if (!q.ctl_s2[HSP_PIN_WR])
               begin
                  d.st = HSP_ST_WRITE;
                  d.acc_ch2 = sel2;
               end
            end
         end
         HSP_ST_READ:
         begin
            d.hdb_drive = 1'b1; // R19
            d.hdb_out = q.acc_addr_line ? q.stat[q.acc_ch2] : q.outb[q.acc_ch2]; // R03
            if (q.ctl_s2[HSP_PIN_RD] || !port_enable)
            begin
               d.st = HSP_ST_IDLE;
               d.hdb_drive = 1'b0; // R19
               if (!q.acc_addr_line && q.ctl_s2[HSP_PIN_RD])
               begin
                  d.stat[q.acc_ch2][HSP_BIT_OUTPUT_FULL] = 1'b0; // R17
               end
            end
         end
         HSP_ST_WRITE:
         begin
            if (q.ctl_s2[HSP_PIN_WR])
            begin
               // Strobe rising edge: byte and address line taken together
               d.st = HSP_ST_IDLE;
               d.push_valid = 1'b1; // R15
               d.push_data = {q.acc_ch2, q.ctl_s2[HSP_PIN_HA], q.dat_s2}; // R04
            end
            else if (!port_enable)
            begin
               d.st = HSP_ST_IDLE;
            end
         end
         default:
         begin
            d.st = HSP_ST_IDLE;
         end
      endcase

      // CPU reads, answered on the next edge
      if (CPU_ADDR == HSP_ADDR_SERIAL_TIMER_CONTROL) // R10
      begin
         rd_val = q.serial_timer_control;
      end
      else if (CPU_ADDR == HSP_ADDR_SYSTEM_CONTROL)
      begin
         rd_val = q.system_control;
      end
      else if (CPU_ADDR == HSP_ADDR_PORT_CONTROL)
      begin
         rd_val = q.port_control; // R08
      end
      else if (CPU_ADDR == HSP_ADDR_INBOUND[0] || CPU_ADDR == HSP_ADDR_INBOUND[1])
      begin
         rd_val = q.inb[CPU_ADDR == HSP_ADDR_INBOUND[1]]; // R05
      end
      else if (CPU_ADDR == HSP_ADDR_OUTBOUND[0] || CPU_ADDR == HSP_ADDR_OUTBOUND[1])
      begin
         rd_val = q.outb[CPU_ADDR == HSP_ADDR_OUTBOUND[1]]; // R06
      end
      else if (CPU_ADDR == HSP_ADDR_STATUS[0] || CPU_ADDR == HSP_ADDR_STATUS[1])
      begin
         rd_val = q.stat[CPU_ADDR == HSP_ADDR_STATUS[1]];
      end
      if (CPU_RD)
      begin
         d.cpu_rdata = rd_val;
      end

      // CPU writes to the shared registers
      if (CPU_WR)
      begin
         if (CPU_ADDR == HSP_ADDR_SERIAL_TIMER_CONTROL)
         begin
            d.serial_timer_control = CPU_WDATA;
         end
         else if (CPU_ADDR == HSP_ADDR_SYSTEM_CONTROL)
         begin
            d.system_control = (CPU_WDATA & ~HSP_SYSTEM_CONTROL_RO)
                             | (q.system_control & HSP_SYSTEM_CONTROL_RO); // R09
         end
         else if (CPU_ADDR == HSP_ADDR_PORT_CONTROL)
         begin
            d.port_control = CPU_WDATA | HSP_PORT_CONTROL_FIXED; // R08
         end
      end

      // Per channel CPU effects; host clear above, so a CPU write wins
      for (int c = 0; c < 2; c++)
      begin
         if (CPU_RD && CPU_ADDR == HSP_ADDR_INBOUND[c])
         begin
            d.stat[c][HSP_BIT_INPUT_FULL] = 1'b0; // R16
         end
         if (CPU_WR && CPU_ADDR == HSP_ADDR_OUTBOUND[c])
         begin
            d.outb[c] = CPU_WDATA; // R06
            d.stat[c][HSP_BIT_OUTPUT_FULL] = 1'b1; // R17
         end
         if (CPU_WR && CPU_ADDR == HSP_ADDR_STATUS[c])
         begin
            d.stat[c] = (CPU_WDATA & HSP_STATUS_WR_MASK)
                      | (d.stat[c] & ~HSP_STATUS_WR_MASK); // R07
         end
      end

      // Queue head lands last so its set beats a same-cycle CPU clear
      if (drain_go)
      begin
         d.inb[drain_ch] = fq.out_data[7:0]; // R05
         d.stat[drain_ch][HSP_BIT_CMD_DATA] = fq.out_data[HSP_FIFO_CMD_BIT]; // R15
         d.stat[drain_ch][HSP_BIT_INPUT_FULL] = 1'b1; // R16
      end

      // Host interrupt and gate levels follow channel status
      d.host_irq[0] = q.stat[0][HSP_BIT_OUTPUT_FULL]; // R14
      d.host_irq[1] = q.stat[1][HSP_BIT_OUTPUT_FULL]; // R14
      d.host_irq[2] = q.stat[1][HSP_BIT_USER_GATE]; // R14
      d.addr_gate = q.stat[0][HSP_BIT_USER_GATE];
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         q <= HSP_REGS_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   assign CPU_RDATA = q.cpu_rdata;
   assign HOST_DATA_BUS_OUT = q.hdb_out; // R13
   assign HOST_DATA_BUS_OE_N = !q.hdb_drive; // R13
   assign HOST_IRQ_ONE = q.host_irq[0];
   assign HOST_IRQ_ELEVEN = q.host_irq[1];
   assign HOST_IRQ_TWELVE = q.host_irq[2];
   assign ADDR_GATE_OUT = q.addr_gate;

   a_disabled_quiet: assert property ( // R18
      @(posedge CLK) disable iff (RST) !port_enable |=> HOST_DATA_BUS_OE_N)
      else $error("bus driven while port disabled");

   a_drive_only_read: assert property ( // R19
      @(posedge CLK) disable iff (RST) !HOST_DATA_BUS_OE_N |-> (q.st == HSP_ST_READ))
      else $error("bus driven outside a host read");

   a_status_on_bus: assert property ( // R03
      @(posedge CLK) disable iff (RST)
      (q.st == HSP_ST_READ && q.acc_addr_line && d.st == HSP_ST_READ)
      |=> HOST_DATA_BUS_OUT == $past(q.acc_ch2 ? q.stat[1] : q.stat[0]))
      else $error("status not returned at address line 1");

   a_outbound_on_bus: assert property ( // R03
      @(posedge CLK) disable iff (RST)
      (q.st == HSP_ST_READ && !q.acc_addr_line && d.st == HSP_ST_READ)
      |=> HOST_DATA_BUS_OUT == $past(q.acc_ch2 ? q.outb[1] : q.outb[0]))
      else $error("outbound byte not returned at address line 0");

   a_output_full_clear: assert property ( // R17
      @(posedge CLK) disable iff (RST)
      (q.st == HSP_ST_READ && q.ctl_s2[HSP_PIN_RD] && port_enable && !q.acc_addr_line
       && !q.acc_ch2 && !(CPU_WR && CPU_ADDR == HSP_ADDR_OUTBOUND[0]))
      |=> !q.stat[0][HSP_BIT_OUTPUT_FULL])
      else $error("output full not cleared by host read");

   a_output_full_set: assert property ( // R17
      @(posedge CLK) disable iff (RST)
      (CPU_WR && CPU_ADDR == HSP_ADDR_OUTBOUND[1])
      |=> q.stat[1][HSP_BIT_OUTPUT_FULL] && q.outb[1] == $past(CPU_WDATA))
      else $error("output full not set by CPU write");

   a_input_full_clear: assert property ( // R16
      @(posedge CLK) disable iff (RST)
      (CPU_RD && CPU_ADDR == HSP_ADDR_INBOUND[0] && !(drain_go && !drain_ch))
      |=> !q.stat[0][HSP_BIT_INPUT_FULL])
      else $error("input full not cleared by CPU read");

   a_inbound_load: assert property ( // R15
      @(posedge CLK) disable iff (RST)
      (drain_go && !drain_ch) |=> q.stat[0][HSP_BIT_INPUT_FULL]
      && q.inb[0] == $past(fq.out_data[7:0])
      && q.stat[0][HSP_BIT_CMD_DATA] == $past(fq.out_data[HSP_FIFO_CMD_BIT]))
      else $error("inbound byte or command flag not loaded");

   a_write_capture: assert property ( // R04
      @(posedge CLK) disable iff (RST)
      (q.st == HSP_ST_WRITE && q.ctl_s2[HSP_PIN_WR])
      |=> q.push_valid && q.push_data[HSP_FIFO_CMD_BIT] == $past(q.ctl_s2[HSP_PIN_HA]))
      else $error("host write not queued with its address line");

   a_sysctl_ro_bit: assert property ( // R09
      @(posedge CLK) disable iff (RST)
      (CPU_WR && CPU_ADDR == HSP_ADDR_SYSTEM_CONTROL)
      |=> q.system_control[3] == $past(q.system_control[3])
      && q.system_control[HSP_BIT_PORT_ENABLE] == $past(CPU_WDATA[HSP_BIT_PORT_ENABLE]))
      else $error("system control write mask wrong");

   a_portctl_fixed: assert property ( // R08
      @(posedge CLK) disable iff (RST) q.port_control[7:3] == 5'h1F)
      else $error("port control fixed bits not one");

   a_status_write: assert property ( // R07
      @(posedge CLK) disable iff (RST)
      (CPU_WR && CPU_ADDR == HSP_ADDR_STATUS[0])
      |=> q.stat[0][7:4] == $past(CPU_WDATA[7:4]) && q.stat[0][2] == $past(CPU_WDATA[2]))
      else $error("status user bits not written");

   a_both_selects_ignored: assert property ( // R02
      @(posedge CLK) disable iff (RST)
      (q.st == HSP_ST_IDLE && !q.ctl_s2[HSP_PIN_SEL1] && !q.ctl_s2[HSP_PIN_SEL2])
      |=> q.st == HSP_ST_IDLE)
      else $error("cycle started with both selects low");

   a_alt_pins_used: assert property ( // R01
      @(posedge CLK) disable iff (RST)
      (alt_sel && !ALT_HOST_WRITE_STROBE_N && !ALT_CHANNEL_TWO_SELECT_N)
      |=> !q.ctl_s1[HSP_PIN_WR] && !q.ctl_s1[HSP_PIN_SEL2])
      else $error("alternate pins not taken");

   a_input_full_two: assert property ( // R16
      @(posedge CLK) disable iff (RST)
      (drain_go && drain_ch) |=> q.stat[1][HSP_BIT_INPUT_FULL]
      && q.inb[1] == $past(fq.out_data[7:0]))
      else $error("second channel inbound byte not loaded");

   a_irq_one_level: assert property ( // R14
      @(posedge CLK) disable iff (RST)
      1'b1 |=> HOST_IRQ_ONE == $past(q.stat[0][HSP_BIT_OUTPUT_FULL]))
      else $error("host interrupt one does not follow output full");
endmodule // hsp_host_port

// File: hsp_pkg.sv
package hsp_pkg;
   // CPU-side byte addresses
   localparam logic [15:0] HSP_ADDR_SERIAL_TIMER_CONTROL = 16'hFFC3;
   localparam logic [15:0] HSP_ADDR_SYSTEM_CONTROL = 16'hFFC4;
   localparam logic [15:0] HSP_ADDR_PORT_CONTROL = 16'hFFF0;
   localparam logic [1:0][15:0] HSP_ADDR_INBOUND = {16'hFFFC, 16'hFFF4};
   localparam logic [1:0][15:0] HSP_ADDR_OUTBOUND = {16'hFFFD, 16'hFFF5};
   localparam logic [1:0][15:0] HSP_ADDR_STATUS = {16'hFFFE, 16'hFFF6};
   // Reset values and access masks
   localparam logic [7:0] HSP_SERIAL_TIMER_RESET = 8'h00;
   localparam logic [7:0] HSP_SYSTEM_CONTROL_RESET = 8'h09;
   localparam logic [7:0] HSP_SYSTEM_CONTROL_RO = 8'h08;
   localparam logic [7:0] HSP_PORT_CONTROL_RESET = 8'hF8;
   localparam logic [7:0] HSP_PORT_CONTROL_FIXED = 8'hF8;
   localparam logic [7:0] HSP_STATUS_RESET = 8'h00;
   localparam logic [7:0] HSP_STATUS_WR_MASK = 8'hF4;
   localparam logic [7:0] HSP_UNMAPPED_READ = 8'h00;
   // Field positions
   localparam int HSP_BIT_ALT_PIN_SELECT = 0;
   localparam int HSP_BIT_PORT_ENABLE = 1;
   localparam int HSP_BIT_OUTPUT_FULL = 0;
   localparam int HSP_BIT_INPUT_FULL = 1;
   localparam int HSP_BIT_CMD_DATA = 3;
   localparam int HSP_BIT_USER_GATE = 4;
   // Synchronised pin vector layout
   localparam int HSP_PIN_RD = 0;
   localparam int HSP_PIN_WR = 1;
   localparam int HSP_PIN_SEL1 = 2;
   localparam int HSP_PIN_SEL2 = 3;
   localparam int HSP_PIN_HA = 4;
   localparam logic [4:0] HSP_PINS_IDLE = 5'h0F;
   // Inbound queue word: {channel, command flag, byte}
   localparam int HSP_FIFO_W = 10;
   localparam int HSP_FIFO_DEPTH = 32;
   localparam int HSP_FIFO_CH_BIT = 9;
   localparam int HSP_FIFO_CMD_BIT = 8;

   typedef enum logic [2:0]
   {
      HSP_ST_IDLE = 3'b001,
      HSP_ST_READ = 3'b010,
      HSP_ST_WRITE = 3'b100
   } hsp_state_t;

   typedef struct packed
   {
      hsp_state_t st;
      logic [4:0] ctl_s1;
      logic [4:0] ctl_s2;
      logic [7:0] dat_s1;
      logic [7:0] dat_s2;
      logic acc_ch2;
      logic acc_addr_line;
      logic hdb_drive;
      logic [7:0] hdb_out;
      logic push_valid;
      logic [HSP_FIFO_W-1:0] push_data;
      logic [7:0] serial_timer_control;
      logic [7:0] system_control;
      logic [7:0] port_control;
      logic [1:0][7:0] inb;
      logic [1:0][7:0] outb;
      logic [1:0][7:0] stat;
      logic [7:0] cpu_rdata;
      logic [2:0] host_irq;
      logic addr_gate;
   } hsp_regs_t;

   localparam hsp_regs_t HSP_REGS_RESET = '{
      st: HSP_ST_IDLE,
      ctl_s1: HSP_PINS_IDLE,
      ctl_s2: HSP_PINS_IDLE,
      serial_timer_control: HSP_SERIAL_TIMER_RESET,
      system_control: HSP_SYSTEM_CONTROL_RESET,
      port_control: HSP_PORT_CONTROL_RESET,
      stat: {HSP_STATUS_RESET, HSP_STATUS_RESET},
      default: '0
   };
endpackage

// File: hsp_fifo_if.sv
`timescale 1ns/1ns
interface hsp_fifo_if #(parameter int W = 10) ();
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;

   modport fifo (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
   modport user (output in_valid, output in_data, output out_ready,
                 input in_ready, input out_valid, input out_data);
endinterface

// File: hsp_fifo.sv
`timescale 1ns/1ns
module hsp_fifo
#(
   parameter int W = 10,
   parameter int DEPTH = 32
)
(
   input wire logic clk,
   input wire logic rst,
   hsp_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);

   // Pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("hsp_fifo: DEPTH must be a power of two, at least 2");
   end

   typedef struct packed
   {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } hsp_fifo_state_t;

   hsp_fifo_state_t q;
   hsp_fifo_state_t d;
   logic push;
   logic pop;

   assign f.in_ready = (q.cnt != DEPTH[AW:0]);
   assign f.out_valid = (q.cnt != '0);
   assign f.out_data = q.mem[q.rp];
   assign push = f.in_valid && f.in_ready;
   assign pop = f.out_valid && f.out_ready;

   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wp] = f.in_data;
         d.wp = q.wp + 1'b1;
      end
      if (pop)
      begin
         d.rp = q.rp + 1'b1;
      end
      if (push && !pop)
      begin
         d.cnt = q.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   a_fifo_count_up: assert property (@(posedge clk) disable iff (rst)
      (push && !pop) |=> (q.cnt == $past(q.cnt) + 1'b1))
      else $error("fifo count did not rise on push");
endmodule // hsp_fifo

// File: hsp_host_model.sv
`timescale 1ns/1ns
module hsp_host_model
(
   input wire logic clk,
   input wire logic use_alt,
   input wire logic [7:0] bus_in,
   output logic rd_n,
   output logic wr_n,
   output logic alt_wr_n,
   output logic sel_one_n,
   output logic sel_two_n,
   output logic alt_sel_two_n,
   output logic ha,
   output logic [7:0] dout,
   output logic done,
   output logic [7:0] rdata
);
   logic wr_s;
   logic sel_two_s;
   // Unused pin of each pair idles high so only the chosen one can act
   assign wr_n = use_alt ? 1'b1 : wr_s;
   assign alt_wr_n = use_alt ? wr_s : 1'b1;
   assign sel_two_n = use_alt ? 1'b1 : sel_two_s;
   assign alt_sel_two_n = use_alt ? sel_two_s : 1'b1;

   initial
   begin
      rd_n = 1'b1;
      wr_s = 1'b1;
      sel_one_n = 1'b1;
      sel_two_s = 1'b1;
      ha = 1'b0;
      dout = 8'h5A;
      done = 1'b0;
      rdata = 8'h00;
   end

   // Channel code: 0 first, 1 second, 2 both selects low
   task automatic cycle(input logic [1:0] ch, input logic a, input logic w, input logic [7:0] d);
      @(posedge clk);
      sel_one_n <= (ch == 2'd1);
      sel_two_s <= (ch == 2'd0);
      ha <= a;
      dout <= d;
      @(posedge clk);
      if (w)
         wr_s <= 1'b0;
      else
         rd_n <= 1'b0;
      repeat (8) @(posedge clk);
      if (!w)
      begin
         rdata <= bus_in;
         done <= 1'b1;
      end
      wr_s <= 1'b1;
      rd_n <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      // Select, address and data held three edges past the strobe release
      repeat (2) @(posedge clk);
      sel_one_n <= 1'b1;
      sel_two_s <= 1'b1;
      dout <= ~dout;
      repeat (3) @(posedge clk);
   endtask
endmodule // hsp_host_model

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import hsp_pkg::*;
   localparam int DEPTH = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] cpu_addr = 16'h0000;
   logic cpu_wr = 1'b0;
   logic cpu_rd = 1'b0;
   logic [7:0] cpu_wdata = 8'h00;
   logic [7:0] cpu_rdata, dev_out, host_d, host_rdata, bus;
   logic rd_n, wr_n, awr_n, sel_one_n, sel_two_n, asel_two_n, ha, oe_n, done, alt = 1'b0;
   logic irq1, irq11, irq12, gate, rd_seen = 1'b0, ch;
   logic [31:0] seed = 32'hb353_1ce4;
   logic [31:0] r;
   logic [7:0] v [5];
   logic [7:0] expq [$];
   int n_mismatch = 0;
   int n_tests = 0;

   always #20 clk = ~clk;
   // Whoever has the bus enabled sets the pin level
   assign bus = !oe_n ? dev_out : host_d;

   hsp_host_port #(.FIFO_DEPTH(DEPTH)) hsp_host_port_i (.CLK(clk), .RST(rst),
      .CPU_ADDR(cpu_addr), .CPU_WR(cpu_wr), .CPU_RD(cpu_rd), .CPU_WDATA(cpu_wdata),
      .CPU_RDATA(cpu_rdata), .HOST_READ_STROBE_N(rd_n), .HOST_WRITE_STROBE_N(wr_n),
      .ALT_HOST_WRITE_STROBE_N(awr_n), .CHANNEL_ONE_SELECT_N(sel_one_n),
      .CHANNEL_TWO_SELECT_N(sel_two_n), .ALT_CHANNEL_TWO_SELECT_N(asel_two_n),
      .HOST_ADDR_LINE(ha), .HOST_DATA_BUS_IN(bus), .HOST_DATA_BUS_OUT(dev_out),
      .HOST_DATA_BUS_OE_N(oe_n), .HOST_IRQ_ONE(irq1), .HOST_IRQ_ELEVEN(irq11),
      .HOST_IRQ_TWELVE(irq12), .ADDR_GATE_OUT(gate));

   hsp_host_model hsp_host_model_i (.clk(clk), .use_alt(alt), .bus_in(bus), .rd_n(rd_n),
      .wr_n(wr_n), .alt_wr_n(awr_n), .sel_one_n(sel_one_n), .sel_two_n(sel_two_n),
      .alt_sel_two_n(asel_two_n), .ha(ha), .dout(host_d), .done(done), .rdata(host_rdata));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      // A result that never came back counts as a mismatch
      if (expq.size() != 0)
         n_mismatch++;
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cpu_w(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      @(posedge clk);
      cpu_wr <= 1'b0;
   endtask

   task automatic cpu_r(input logic [15:0] a, input logic [7:0] e);
      expq.push_back(e);
      @(posedge clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge clk);
      cpu_rd <= 1'b0;
   endtask

   task automatic host(input logic [1:0] c, input logic a, input logic w, input logic [7:0] d,
                       input logic [7:0] e);
      if (!w)
         expq.push_back(e);
      hsp_host_model_i.cycle(c, a, w, d);
   endtask

   // Results come back in issue order, so one queue serves both buses
   always @(posedge clk)
   begin
      if (rd_seen || done)
         chk(rd_seen ? cpu_rdata : host_rdata, expq.pop_front());
      rd_seen <= cpu_rd;
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      cpu_r(HSP_ADDR_SERIAL_TIMER_CONTROL, 8'h00);
      cpu_r(HSP_ADDR_SYSTEM_CONTROL, 8'h09);
      cpu_r(HSP_ADDR_PORT_CONTROL, 8'hF8);
      cpu_w(16'hFF00, 8'hA5);
      cpu_r(16'hFF00, 8'h00);
      host(2'd0, 1'b0, 1'b1, 8'h3C, 8'h00);
      cpu_r(HSP_ADDR_STATUS[0], 8'h00);
      cpu_w(HSP_ADDR_SYSTEM_CONTROL, 8'h00);
      cpu_r(HSP_ADDR_SYSTEM_CONTROL, 8'h08);
      cpu_w(HSP_ADDR_PORT_CONTROL, 8'h07);
      cpu_r(HSP_ADDR_PORT_CONTROL, 8'hFF);
      for (int i = 0; i < 2; i++)
      begin
         cpu_r(HSP_ADDR_STATUS[i], 8'h00);
         cpu_w(HSP_ADDR_STATUS[i], 8'hFF);
         cpu_r(HSP_ADDR_STATUS[i], 8'hF4);
         chk({7'h00, i ? irq12 : gate}, 8'h01);
         cpu_w(HSP_ADDR_STATUS[i], 8'h00);
         cpu_w(HSP_ADDR_INBOUND[i], 8'hFF);
         cpu_r(HSP_ADDR_INBOUND[i], 8'h00);
      end
      cpu_w(HSP_ADDR_SYSTEM_CONTROL, 8'h03);
      cpu_r(HSP_ADDR_SYSTEM_CONTROL, 8'h0B);
      // Both selects low must be ignored
      host(2'd2, 1'b1, 1'b1, 8'h77, 8'h00);
      cpu_r(HSP_ADDR_STATUS[0], 8'h00);
      cpu_r(HSP_ADDR_STATUS[1], 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         ch = i[0];
         alt <= i[1];
         cpu_w(HSP_ADDR_SERIAL_TIMER_CONTROL, {7'h00, i[1]});
         r = xs();
         host({1'b0, ch}, r[8], 1'b1, r[7:0], 8'h00);
         cpu_r(HSP_ADDR_STATUS[ch], {4'h0, r[8], 3'b010});
         cpu_r(HSP_ADDR_INBOUND[ch], r[7:0]);
         cpu_r(HSP_ADDR_STATUS[ch], {4'h0, r[8], 3'b000});
         cpu_w(HSP_ADDR_OUTBOUND[ch], r[23:16]);
         cpu_r(HSP_ADDR_OUTBOUND[ch], r[23:16]);
         chk({7'h00, ch ? irq11 : irq1}, 8'h01);
         host({1'b0, ch}, 1'b1, 1'b0, 8'h00, {4'h0, r[8], 3'b001});
         host({1'b0, ch}, 1'b0, 1'b0, 8'h00, r[23:16]);
         cpu_r(HSP_ADDR_STATUS[ch], {4'h0, r[8], 3'b000});
         chk({7'h00, oe_n}, 8'h01);
      end
      alt <= 1'b0;
      cpu_w(HSP_ADDR_SERIAL_TIMER_CONTROL, 8'h00);
      // Queue fills while the full inbound register stalls its head
      for (int j = 0; j < 5; j++)
      begin
         r = xs();
         v[j] = r[7:0];
         host(2'd0, 1'b0, 1'b1, v[j], 8'h00);
      end
      for (int j = 0; j < 5; j++)
      begin
         cpu_r(HSP_ADDR_INBOUND[0], v[j]);
         repeat (4) @(posedge clk);
      end
      cpu_r(HSP_ADDR_STATUS[0], 8'h00);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule // tb_top
